// ==== include/pwmdb_pkg.sv ====
// Constants, field layouts and carrier types of the PWM duty block
package pwmdb_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_PERIOD = 12'h000;
   localparam logic [11:0] OFS_DUTY_LO = 12'h004;
   localparam logic [11:0] OFS_CTRL = 12'h008;
   localparam logic [11:0] OFS_SHADOW = 12'h00C;
   localparam logic [11:0] OFS_TCTRL = 12'h010;
   localparam logic [11:0] OFS_TIMER = 12'h014;
   localparam logic [11:0] OFS_DIR = 12'h018;
   localparam logic [11:0] OFS_TBSEL = 12'hF50;

   // ------------------------------------------------------------
   // Field positions, masks and codes
   // ------------------------------------------------------------
   localparam int CTRL_FRAC_LSB = 4;
   localparam int CTRL_MODE_LSB = 0;
   localparam logic [3:0] MODE_PWM = 4'hC;
   localparam logic [7:0] CTRL_MASK = 8'h3F;
   localparam int TCTRL_PS_LSB = 0;
   localparam int TCTRL_ON = 2;
   localparam logic [7:0] TCTRL_MASK = 8'h07;
   localparam int DIR_BIT = 0;
   localparam logic [7:0] DIR_MASK = 8'h01;
   localparam int TB_C10 = 4;
   localparam int TB_C9 = 2;
   localparam int TB_C8_LSB = 0;
   localparam logic [7:0] TB_MASK = 8'h17;

   // Prescale codes and last value of the sub-cycle counter
   localparam logic [1:0] PS_1 = 2'h0;
   localparam logic [1:0] PS_4 = 2'h1;
   localparam logic [5:0] SUB_LAST_1 = 6'h03;
   localparam logic [5:0] SUB_LAST_4 = 6'h0F;
   localparam logic [5:0] SUB_LAST_16 = 6'h3F;
   localparam logic [5:0] SUB_ONE = 6'h01;
   localparam logic [5:0] SUB_ZERO = 6'h00;
   localparam int SUB_Q_LSB = 0;
   localparam int SUB_P4_LSB = 2;
   localparam int SUB_P16_LSB = 4;

   // Timebase pair codes: binary channel-eight field codes, one-hot outputs
   localparam logic [1:0] C8_T2 = 2'h0;
   localparam logic [1:0] C8_T4 = 2'h1;
   localparam logic [1:0] C8_T6 = 2'h2;
   localparam logic [2:0] TB_T2 = 3'h1;
   localparam logic [2:0] TB_T4 = 3'h2;
   localparam logic [2:0] TB_T6 = 3'h4;
   localparam logic [2:0] TB_NONE = 3'h0;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h01;
   localparam logic [7:0] TIMER_ONE = 8'h01;
   localparam logic [9:0] DUTY_ZERO = 10'h000;
   localparam logic [31:0] RD_ZERO = 32'h00000000;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pwmdb_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pwmdb_apb_rsp_t;

   typedef struct packed {
      logic [2:0] ch10;
      logic [2:0] ch9;
      logic [2:0] ch8;
   } pwmdb_tbsel_t;

endpackage

// ==== core/pwmdb_top.sv ====
// PWM duty double buffer with period timer and timebase select
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
//
// Contract
// RL1: Duty is duty byte over two fraction bits.
// RL2: High time is duty times clock times prescale.
// RL3: Duty loads into shadow only at period match.
// RL4: Shadow ignores writes while in pulse-width mode.
// RL5: Shadow plus two-bit latch hold active duty.
// RL6: Clear pin when shadow equals extended timer count.
// RL7: Duty beyond period keeps pin high all period.
// RL8: Software sets period, duty, pin, timer, mode.
// RL9: Channel ten uses pair one/two; one reserved.
// RL10: Channel nine selects pair one/two or one/four.
// RL11: Channel eight selects two, four, six; 11 reserved.
// RL12: Period match restarts timer, raises pin unless zero.
module pwmdb_top (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire pwmdb_pkg::pwmdb_apb_req_t APB_REQ,
   output pwmdb_pkg::pwmdb_apb_rsp_t APB_RSP,
   output logic PWM_OUT,
   output logic PWM_OE_N,
   output pwmdb_pkg::pwmdb_tbsel_t TB_SEL
);
   import pwmdb_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] period_limit;
   logic [7:0] duty_low_byte;
   logic [7:0] channel_control;
   logic [7:0] duty_shadow;
   logic [1:0] duty_latch;
   logic [7:0] period_timer_control;
   logic [7:0] pin_direction;
   logic [7:0] channel_timebase_select_upper;
   logic [7:0] period_timer;
   logic [5:0] sub_count;
   logic pin;
   logic oe_n;
   pwmdb_tbsel_t tb_sel;
   pwmdb_apb_rsp_t rsp;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire setup_phase = APB_REQ.psel & ~APB_REQ.penable;
   wire wr_done = APB_REQ.psel & APB_REQ.penable & rsp.pready
                  & APB_REQ.pwrite;
   wire [7:0] wbyte = APB_REQ.pwdata[7:0];
   wire hit_period = APB_REQ.paddr == OFS_PERIOD;
   wire hit_duty = APB_REQ.paddr == OFS_DUTY_LO;
   wire hit_ctrl = APB_REQ.paddr == OFS_CTRL;
   wire hit_shadow = APB_REQ.paddr == OFS_SHADOW;
   wire hit_tctrl = APB_REQ.paddr == OFS_TCTRL;
   wire hit_timer = APB_REQ.paddr == OFS_TIMER;
   wire hit_dir = APB_REQ.paddr == OFS_DIR;
   wire hit_tbsel = APB_REQ.paddr == OFS_TBSEL;
   wire mapped = hit_period | hit_duty | hit_ctrl | hit_shadow
                 | hit_tctrl | hit_timer | hit_dir | hit_tbsel;
   wire wr_period = wr_done & hit_period;
   wire wr_duty = wr_done & hit_duty;
   wire wr_ctrl = wr_done & hit_ctrl;
   wire wr_shadow = wr_done & hit_shadow;
   wire wr_tctrl = wr_done & hit_tctrl;
   wire wr_dir = wr_done & hit_dir;
   wire wr_tbsel = wr_done & hit_tbsel;

   // ------------------------------------------------------------
   // Read selection
   // ------------------------------------------------------------
   wire [7:0] rd_byte =
      hit_period ? period_limit :
      hit_duty ? duty_low_byte :
      hit_ctrl ? channel_control :
      hit_shadow ? duty_shadow :
      hit_tctrl ? period_timer_control :
      hit_timer ? period_timer :
      hit_dir ? pin_direction :
      hit_tbsel ? channel_timebase_select_upper :
      RST_BYTE;
   wire [31:0] rd_word = {24'h000000, rd_byte};

   // ------------------------------------------------------------
   // Mode and timebase
   // ------------------------------------------------------------
   wire pwm_mode =
      channel_control[CTRL_MODE_LSB +: 4] == MODE_PWM;
   wire timer_on = period_timer_control[TCTRL_ON];
   wire [1:0] ps_code = period_timer_control[TCTRL_PS_LSB +: 2];
   // Sub-cycle counter spans four clocks times the prescale ratio
   wire [5:0] sub_last =                                     // see RL2
      (ps_code == PS_1) ? SUB_LAST_1 :
      (ps_code == PS_4) ? SUB_LAST_4 :
      SUB_LAST_16;
   wire sub_wrap = sub_count == sub_last;
   wire timer_tick = timer_on & sub_wrap;
   wire period_end = timer_tick & (period_timer == period_limit);

   // ------------------------------------------------------------
   // Duty path
   // ------------------------------------------------------------
   wire [9:0] duty_new =                                     // see RL1
      {duty_low_byte, channel_control[CTRL_FRAC_LSB +: 2]};
   wire [9:0] duty_active = {duty_shadow, duty_latch};       // see RL5
   wire load_shadow = pwm_mode & period_end;                 // see RL3

   // ------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------
   wire [5:0] next_sub_count =
      ~timer_on ? sub_count :
      sub_wrap ? SUB_ZERO :
      sub_count + SUB_ONE;
   wire [7:0] next_period_timer =
      ~timer_tick ? period_timer :
      period_end ? RST_BYTE :                               // see RL12
      period_timer + TIMER_ONE;
   // Two extension bits: quarter-cycle phase or prescaler bits
   wire [1:0] ext_low =                                      // see RL6
      (ps_code == PS_1) ? next_sub_count[SUB_Q_LSB +: 2] :
      (ps_code == PS_4) ? next_sub_count[SUB_P4_LSB +: 2] :
      next_sub_count[SUB_P16_LSB +: 2];
   // Count of the coming cycle, so the pin is already low in the
   // cycle whose count equals the duty: high for duty counts
   wire [9:0] ext_count = {next_period_timer, ext_low};
   // A duty above the extended period never matches, so the pin
   // stays high for the whole period
   wire clear_hit = ext_count == duty_active;         // see RL6, RL7
   wire [7:0] next_duty_shadow =
      load_shadow ? duty_new[9:2] :                         // see RL3
      (wr_shadow & ~pwm_mode) ? wbyte :                     // see RL4
      duty_shadow;
   wire [1:0] next_duty_latch =
      load_shadow ? duty_new[1:0] : duty_latch;             // see RL5
   wire next_pin =
      ~pwm_mode ? 1'b0 :
      period_end ? (duty_new != DUTY_ZERO) :                // see RL12
      clear_hit ? 1'b0 :                                    // see RL6
      pin;
   // Pin is driven only once software made it an output
   wire next_oe_n =                                         // see RL8
      pin_direction[DIR_BIT] | ~pwm_mode;

   // ------------------------------------------------------------
   // Timebase pair decode
   // ------------------------------------------------------------
   wire [1:0] c8_code =
      channel_timebase_select_upper[TB_C8_LSB +: 2];
   wire [2:0] next_ch10 =                                    // see RL9
      channel_timebase_select_upper[TB_C10] ? TB_NONE : TB_T2;
   wire [2:0] next_ch9 =                                    // see RL10
      channel_timebase_select_upper[TB_C9] ? TB_T4 : TB_T2;
   wire [2:0] next_ch8 =                                    // see RL11
      (c8_code == C8_T2) ? TB_T2 :
      (c8_code == C8_T4) ? TB_T4 :
      (c8_code == C8_T6) ? TB_T6 :
      TB_NONE;

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         period_limit <= RST_BYTE;
         duty_low_byte <= RST_BYTE;
         channel_control <= RST_BYTE;
         period_timer_control <= RST_BYTE;
         pin_direction <= RST_DIR;
         channel_timebase_select_upper <= RST_BYTE;
      end else begin
         if (wr_period) begin
            period_limit <= wbyte;
         end
         // Duty low byte accepts writes at any time
         if (wr_duty) begin
            duty_low_byte <= wbyte;                         // see RL3
         end
         if (wr_ctrl) begin
            channel_control <= wbyte & CTRL_MASK;
         end
         if (wr_tctrl) begin
            period_timer_control <= wbyte & TCTRL_MASK;
         end
         if (wr_dir) begin
            pin_direction <= wbyte & DIR_MASK;
         end
         if (wr_tbsel) begin
            channel_timebase_select_upper <= wbyte & TB_MASK;
         end
      end
   end

   // ------------------------------------------------------------
   // Timer, shadow and pin
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         sub_count <= SUB_ZERO;
         period_timer <= RST_BYTE;
         duty_shadow <= RST_BYTE;
         duty_latch <= 2'h0;
         pin <= 1'b0;
         oe_n <= 1'b1;
      end else begin
         sub_count <= next_sub_count;
         period_timer <= next_period_timer;
         duty_shadow <= next_duty_shadow;
         duty_latch <= next_duty_latch;
         pin <= next_pin;
         oe_n <= next_oe_n;
      end
   end

   // ------------------------------------------------------------
   // Timebase outputs
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         tb_sel <= '{ch10: TB_T2, ch9: TB_T2, ch8: TB_T2};
      end else begin
         tb_sel <= '{ch10: next_ch10, ch9: next_ch9, ch8: next_ch8};
      end
   end

   // ------------------------------------------------------------
   // Bus answer: one wait-free access cycle after setup
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         rsp <= '{pready: 1'b0, pslverr: 1'b0, prdata: RD_ZERO};
      end else begin
         rsp.pready <= setup_phase;
         rsp.pslverr <= setup_phase & ~mapped;
         rsp.prdata <= (setup_phase & ~APB_REQ.pwrite) ? rd_word
                       : RD_ZERO;
      end
   end

   assign APB_RSP = rsp;
   assign PWM_OUT = pin;
   assign PWM_OE_N = oe_n;
   assign TB_SEL = tb_sel;

endmodule

// ==== bench/pwmdb_assertions.sv ====
// Port checker for the PWM duty double buffer
`timescale 1ns/1ns
module pwmdb_assertions (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire pwmdb_pkg::pwmdb_apb_req_t APB_REQ,
   input wire pwmdb_pkg::pwmdb_apb_rsp_t APB_RSP,
   input wire logic PWM_OUT,
   input wire logic PWM_OE_N,
   input wire pwmdb_pkg::pwmdb_tbsel_t TB_SEL
);
   import pwmdb_pkg::*;
   wire logic tb_wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite
      && APB_RSP.pready && APB_REQ.paddr == OFS_TBSEL;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (SYS_RST);
   property p_ready;
      APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("no ready after setup");
   property p_pulse;
      APB_RSP.pready |=> !APB_RSP.pready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready held too long");
   property p_err;
      APB_RSP.pslverr |-> APB_RSP.pready;
   endproperty
   a_err: assert property (p_err)
      else $error("error without ready");
   property p_c10;
      TB_SEL.ch10 == TB_T2 || TB_SEL.ch10 == TB_NONE;
   endproperty
   a_c10: assert property (p_c10)
      else $error("bad channel ten base");
   property p_c9;
      tb_wr && !APB_REQ.pwdata[2] |-> ##[1:2] TB_SEL.ch9 == TB_T2;
   endproperty
   a_c9: assert property (p_c9)
      else $error("channel nine base wrong");
   property p_c8;
      tb_wr && APB_REQ.pwdata[1:0] == C8_T6 |-> ##[1:2] TB_SEL.ch8 == TB_T6;
   endproperty
   a_c8: assert property (p_c8)
      else $error("channel eight base wrong");
   property p_c8r;
      tb_wr && APB_REQ.pwdata[1:0] == 2'h3 |-> ##[1:2] TB_SEL.ch8 == TB_NONE;
   endproperty
   a_c8r: assert property (p_c8r)
      else $error("reserved code decoded");
   property p_rst;
      disable iff (1'b0) SYS_RST |=> !PWM_OUT && PWM_OE_N;
   endproperty
   a_rst: assert property (p_rst)
      else $error("pin active in reset");
endmodule

// ==== bench/pwmdb_load.sv ====
// Load on the PWM pin, measuring each high time in clocks
`timescale 1ns/1ns
module pwmdb_load (
   input wire logic clk,
   input wire logic drive,
   input wire logic oe_n,
   output logic level,
   output logic [15:0] run,
   output logic [15:0] last_high
);
   // Pull-down holds the pin low while it is not driven
   assign level = oe_n ? 1'b0 : drive;
   initial begin
      run = 16'h0000;
      last_high = 16'h0000;
   end
   always @(posedge clk) begin
      if (level === 1'b1) begin
         run <= run + 16'h0001;
      end else begin
         if (run != 16'h0000) last_high <= run;
         run <= 16'h0000;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench of the PWM duty double buffer
`timescale 1ns/1ns
module tb_top;
   import pwmdb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pwmdb_apb_req_t req = '0;
   pwmdb_apb_rsp_t rsp;
   pwmdb_tbsel_t tbsel;
   logic pwm_out, pwm_oe_n, pin_hi, serr;
   logic [15:0] run, last_high;
   logic [31:0] rd;
   int err_total = 0;
   int samples_checked = 0;
   initial begin
      forever #2 clk = ~clk;
   end
   pwmdb_top dut (.CORE_CLK(clk), .SYS_RST(rst), .APB_REQ(req),
      .APB_RSP(rsp), .PWM_OUT(pwm_out), .PWM_OE_N(pwm_oe_n), .TB_SEL(tbsel));
   pwmdb_load load (.clk(clk), .drive(pwm_out), .oe_n(pwm_oe_n),
      .level(pin_hi), .run(run), .last_high(last_high));
   task automatic close_out;
      $display("Checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d);
      int n;
      @(posedge clk);
      req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a,
         pwdata:{24'h000000, d}};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      serr = rsp.pslverr;
      req <= '0;
      if (n >= 20) begin
         chk("pready", 32'h1, 32'h0);
         close_out();
      end
   endtask
   task automatic rchk(input string what, input logic [11:0] a,
      input logic [31:0] e);
      apb(1'b0, a, 8'h00);
      chk(what, e, rd);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic s_reset;
      chk("tbsel pins", 32'h49, {23'h0, tbsel});
      chk("oe", 32'h1, {31'h0, pwm_oe_n});
      rchk("tbsel reg", OFS_TBSEL, 32'h0);
   endtask
   task automatic s_tbsel;
      logic [2:0] c8 [4] = '{TB_T2, TB_T4, TB_T6, TB_NONE};
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         d = {5'h00, i[2:0]};
         apb(1'b1, OFS_TBSEL, d);
         rchk("tbsel", OFS_TBSEL, {24'h0, d});
         chk("ch9", {29'h0, d[2] ? TB_T4 : TB_T2}, {29'h0, tbsel.ch9});
         chk("ch8", {29'h0, c8[d[1:0]]}, {29'h0, tbsel.ch8});
         chk("ch10", {29'h0, TB_T2}, {29'h0, tbsel.ch10});
      end
      apb(1'b1, OFS_TBSEL, 8'hEB);
      rchk("tbsel mask", OFS_TBSEL, 32'h03);
      apb(1'b0, 12'h020, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, serr});
      apb(1'b1, OFS_SHADOW, 8'h55);
      rchk("shadow rw", OFS_SHADOW, 32'h55);
   endtask
   task automatic s_pwm;
      int n;
      apb(1'b1, OFS_PERIOD, 8'h03);
      apb(1'b1, OFS_DUTY_LO, 8'h01);
      apb(1'b1, OFS_CTRL, 8'h20);
      apb(1'b1, OFS_DIR, 8'h00);
      apb(1'b1, OFS_TCTRL, 8'h04);
      apb(1'b1, OFS_CTRL, 8'h2C);
      idle(60);
      chk("high ps1", 32'd6, {16'h0, last_high});
      chk("oe on", 32'h0, {31'h0, pwm_oe_n});
      n = 0;
      while (run !== 16'h0001 && n < 100) begin
         @(posedge clk);
         n++;
      end
      apb(1'b1, OFS_DUTY_LO, 8'h02);
      rchk("shadow old", OFS_SHADOW, 32'h01);
      idle(40);
      rchk("shadow new", OFS_SHADOW, 32'h02);
      chk("high new", 32'd10, {16'h0, last_high});
      apb(1'b1, OFS_SHADOW, 8'h55);
      rchk("shadow ro", OFS_SHADOW, 32'h02);
      apb(1'b1, OFS_DUTY_LO, 8'hFF);
      idle(40);
      chk("never cleared", 32'h1, {31'h0, run > 16'd20});
      apb(1'b1, OFS_DUTY_LO, 8'h00);
      apb(1'b1, OFS_CTRL, 8'h0C);
      idle(40);
      chk("zero duty", 32'h0, {16'h0, run});
      apb(1'b1, OFS_DUTY_LO, 8'h01);
      apb(1'b1, OFS_CTRL, 8'h2C);
      apb(1'b1, OFS_TCTRL, 8'h05);
      idle(200);
      chk("high ps4", 32'd24, {16'h0, last_high});
      apb(1'b1, OFS_CTRL, 8'h20);
      idle(2);
      chk("pin off", 32'h0, {31'h0, pwm_out});
      chk("oe off", 32'h1, {31'h0, pwm_oe_n});
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_tbsel();
      s_pwm();
      close_out();
   end
endmodule
bind pwmdb_top pwmdb_assertions chk_i (.CORE_CLK(CORE_CLK),
   .SYS_RST(SYS_RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
   .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N), .TB_SEL(TB_SEL));
